// File: hdl/multirate_phy_mac_data_port.sv
// device end of the multi-rate data port, plus the crossing buffer
// assumes: clk is the recovered/core side, link.linkClk the parallel clock
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////
// gray-pointer crossing buffer
module async_fifo #(
   parameter int W  = 8,
   parameter int AW = 3
) (
   input  wire logic         wClk,
   input  wire logic         wRstn,
   input  wire logic         wValid,
   input  wire logic [W-1:0] wData,
   output logic              wReady,
   input  wire logic         rClk,
   input  wire logic         rRstn,
   output logic              rValid,
   output logic [W-1:0]      rData,
   input  wire logic         rReady
);
   logic [W-1:0] mem_q [2**AW];
   logic [AW:0]  wBin_q;
   logic [AW:0]  wBin_d;
   logic [AW:0]  wGray_q;
   logic [AW:0]  rBin_q;
   logic [AW:0]  rBin_d;
   logic [AW:0]  rGray_q;
   logic [AW:0]  rgS1_q;
   logic [AW:0]  rgS2_q;
   logic [AW:0]  wgS1_q;
   logic [AW:0]  wgS2_q;

   function automatic logic [AW:0] to_gray(input logic [AW:0] b);
      return b ^ (b >> 1);
   endfunction : to_gray

   // full: top two gray bits inverted against the synced read pointer
   assign wReady = wGray_q != {~rgS2_q[AW:AW-1], rgS2_q[AW-2:0]};
   assign rValid = rGray_q != wgS2_q;
   assign rData  = mem_q[rBin_q[AW-1:0]];

   always_comb begin
      wBin_d = wBin_q + (AW+1)'(wValid && wReady);
      rBin_d = rBin_q + (AW+1)'(rValid && rReady);
   end

   always_ff @(posedge wClk) begin
      if (wValid && wReady) begin
         mem_q[wBin_q[AW-1:0]] <= wData;
      end
   end

   always_ff @(posedge wClk or negedge wRstn) begin
      if (!wRstn) begin
         wBin_q  <= '0;
         wGray_q <= '0;
         rgS1_q  <= '0;
         rgS2_q  <= '0;
      end else begin
         wBin_q  <= wBin_d;
         wGray_q <= to_gray(wBin_d);
         rgS1_q  <= rGray_q;
         rgS2_q  <= rgS1_q;
      end
   end

   always_ff @(posedge rClk or negedge rRstn) begin
      if (!rRstn) begin
         rBin_q  <= '0;
         rGray_q <= '0;
         wgS1_q  <= '0;
         wgS2_q  <= '0;
      end else begin
         rBin_q  <= rBin_d;
         rGray_q <= to_gray(rBin_d);
         wgS1_q  <= wGray_q;
         wgS2_q  <= wgS1_q;
      end
   end
endmodule : async_fifo

////////////////////////////////////////////////////////////////////////
// device end
module multirate_phy_mac_data_port
   import mr_link_pkg::*;
#(
   parameter bit PTP_EN = 1'b1,
   parameter int FAW    = FIFO_AW
) (
   input  wire logic                  clk,
   input  wire logic                  rstn,
   mr_link_if.phy                     link,
   input  wire logic [1:0]            speedMode,
   output logic [NARROW_W-1:0]        txWord,
   output logic [LANES-1:0]           txLaneEn,
   output logic [LANES-1:0]           txLaneErr,
   output logic                       txWordValid,
   output logic [WIDE_W-1:0]          txWideData,
   output logic [WIDE_LANES-1:0]      txWideCtrl,
   output logic                       txWideValid,
   input  wire logic [NARROW_W-1:0]   rxWord,
   input  wire logic [LANES-1:0]      rxLaneValid,
   input  wire logic [LANES-1:0]      rxLaneErr,
   input  wire logic                  rxWordValid,
   output logic                       rxWordReady,
   input  wire logic [WIDE_W-1:0]     rxWideData,
   input  wire logic [WIDE_LANES-1:0] rxWideCtrl,
   input  wire logic                  rxWideValid,
   output logic                       rxWideReady
);
   logic [1:0]           lrst_q;
   logic                 linkRstn;
   logic [1:0]           crst_q;
   logic                 coreRstn;
   logic [1:0]           spS1_q, spS1_d;
   logic [1:0]           spS2_q, spS2_d;
   logic [NTX_W-1:0]     txCap_q, txCap_d;
   logic [WFIFO_W-1:0]   wTxCap_q, wTxCap_d;
   logic                 wTxCapV_q, wTxCapV_d;
   logic [NTX_W-1:0]     nRx_q, nRx_d;
   logic [WFIFO_W-1:0]   wRx_q, wRx_d;
   logic                 wRxV_q, wRxV_d;
   logic [PACE_W-1:0]    pace_q, pace_d;
   logic [DELAY_W-1:0]   txDly_q, txDly_d;
   logic [DELAY_W-1:0]   rxDly_q, rxDly_d;
   logic                 tick;
   logic                 txnPush;
   logic                 rxnAvail;
   logic [NTX_W-1:0]     rxnData;
   logic                 rxwAvail;
   logic [WFIFO_W-1:0]   rxwData;
   logic [NTX_W-1:0]     txnOut;
   logic [WFIFO_W-1:0]   txwOut;

   ////////////////////////////////////////////////////////////////////
   // link-domain reset release
   always_ff @(posedge link.linkClk or negedge rstn) begin
      if (!rstn) begin
         lrst_q <= 2'h0;
      end else begin
         lrst_q <= {lrst_q[0], 1'b1};
      end
   end
   assign linkRstn = lrst_q[1];

   // core-domain release, so the buffer pointers leave reset on a clean clk edge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         crst_q <= 2'h0;
      end else begin
         crst_q <= {crst_q[0], 1'b1};
      end
   end
   assign coreRstn = crst_q[1];

   ////////////////////////////////////////////////////////////////////
   // link-domain next state
   assign tick    = pace_q == '0;
   assign txnPush = |txCap_q[NARROW_W +: 2*LANES];

   always_comb begin
      // speed is quasi-static, a level sync is enough
      spS1_d    = speedMode;
      spS2_d    = spS1_q;
      txCap_d   = {link.narrowTxLaneError, link.narrowTxLaneEnable, link.narrowTxWord};
      wTxCap_d  = {link.wideTxCtrl, link.wideTxData};
      wTxCapV_d = link.wideTxValid;
      // idle when drained: this is the rate-match slip point
      nRx_d     = rxnAvail ? rxnData : '0;
      pace_d    = tick ? pace_period(spS2_q) - 4'h1 : pace_q - 4'h1;
      wRxV_d    = tick;
      wRx_d     = wRx_q;
      if (tick) begin
         wRx_d = rxwAvail ? rxwData : WIDE_IDLE;
      end
      txDly_d   = PTP_EN ? {TX_LAT_CYC, LAT_FRAC} : '0;
      rxDly_d   = PTP_EN ? {RX_LAT_CYC, LAT_FRAC} : '0;
   end

   always_ff @(posedge link.linkClk or negedge linkRstn) begin
      if (!linkRstn) begin
         spS1_q    <= SPEED_1G;
         spS2_q    <= SPEED_1G;
         txCap_q   <= '0;
         wTxCap_q  <= '0;
         wTxCapV_q <= 1'b0;
         nRx_q     <= '0;
         wRx_q     <= '0;
         wRxV_q    <= 1'b0;
         pace_q    <= '0;
         txDly_q   <= '0;
         rxDly_q   <= '0;
      end else begin
         spS1_q    <= spS1_d;
         spS2_q    <= spS2_d;
         txCap_q   <= txCap_d;
         wTxCap_q  <= wTxCap_d;
         wTxCapV_q <= wTxCapV_d;
         nRx_q     <= nRx_d;
         wRx_q     <= wRx_d;
         wRxV_q    <= wRxV_d;
         pace_q    <= pace_d;
         txDly_q   <= txDly_d;
         rxDly_q   <= rxDly_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // link outputs, low byte is the earlier octet
   assign link.narrowRxWord      = nRx_q[NARROW_W-1:0];
   assign link.narrowRxLaneValid = nRx_q[NARROW_W +: LANES];
   assign link.narrowRxLaneError = nRx_q[NARROW_W+LANES +: LANES];
   assign link.wideRxData        = wRx_q[WIDE_W-1:0];
   assign link.wideRxCtrl        = wRx_q[WIDE_W +: WIDE_LANES];
   assign link.wideRxValid       = wRxV_q;
   assign link.txPathDelayValue  = txDly_q;
   assign link.rxPathDelayValue  = rxDly_q;

   ////////////////////////////////////////////////////////////////////
   // crossings; the core side never stalls transmit
   async_fifo #(.W(NTX_W), .AW(FAW)) u_txn (
      .wClk(link.linkClk), .wRstn(linkRstn), .wValid(txnPush), .wData(txCap_q), .wReady(),
      .rClk(clk), .rRstn(coreRstn), .rValid(txWordValid), .rData(txnOut), .rReady(1'b1));

   async_fifo #(.W(WFIFO_W), .AW(FAW)) u_txw (
      .wClk(link.linkClk), .wRstn(linkRstn), .wValid(wTxCapV_q), .wData(wTxCap_q), .wReady(),
      .rClk(clk), .rRstn(coreRstn), .rValid(txWideValid), .rData(txwOut), .rReady(1'b1));

   async_fifo #(.W(NTX_W), .AW(FAW)) u_rxn (
      .wClk(clk), .wRstn(coreRstn), .wValid(rxWordValid), .wData({rxLaneErr, rxLaneValid, rxWord}),
      .wReady(rxWordReady),
      .rClk(link.linkClk), .rRstn(linkRstn), .rValid(rxnAvail), .rData(rxnData), .rReady(1'b1));

   async_fifo #(.W(WFIFO_W), .AW(FAW)) u_rxw (
      .wClk(clk), .wRstn(coreRstn), .wValid(rxWideValid), .wData({rxWideCtrl, rxWideData}),
      .wReady(rxWideReady),
      .rClk(link.linkClk), .rRstn(linkRstn), .rValid(rxwAvail), .rData(rxwData), .rReady(tick));

   assign txWord     = txnOut[NARROW_W-1:0];
   assign txLaneEn   = txnOut[NARROW_W +: LANES];
   assign txLaneErr  = txnOut[NARROW_W+LANES +: LANES];
   assign txWideData = txwOut[WIDE_W-1:0];
   assign txWideCtrl = txwOut[WIDE_W +: WIDE_LANES];
endmodule : multirate_phy_mac_data_port
`default_nettype wire

// File: hdl/mr_link_pkg.sv
// constants shared by both ends of the multi-rate parallel data port
// assumes: both ends and the link interface import this package whole
package mr_link_pkg;
   // narrow two-lane port
   localparam int NARROW_W = 16;
   localparam int LANES    = 2;
   localparam int NTX_W    = NARROW_W + 2 * LANES;
   // wide port
   localparam int WIDE_W     = 64;
   localparam int WIDE_LANES = WIDE_W / 8;
   localparam int WFIFO_W    = WIDE_W + WIDE_LANES;
   // parallel clock rates, kHz
   localparam int NARROW_CLK_1G_KHZ  = 62500;
   localparam int NARROW_CLK_2G5_KHZ = 156250;
   localparam int WIDE_CLK_KHZ       = 156250;
   // path delay value layout
   localparam int DELAY_W      = 22;
   localparam int DELAY_FRAC_W = 10;
   localparam int DELAY_INT_W  = DELAY_W - DELAY_FRAC_W;
   localparam logic [DELAY_INT_W-1:0]  TX_LAT_CYC = 12'h006;
   localparam logic [DELAY_INT_W-1:0]  RX_LAT_CYC = 12'h007;
   localparam logic [DELAY_FRAC_W-1:0] LAT_FRAC   = 10'h000;
   // crossing buffers
   localparam int FIFO_AW = 3;
   // speed codes
   localparam logic [1:0] SPEED_1G  = 2'h0;
   localparam logic [1:0] SPEED_2G5 = 2'h1;
   localparam logic [1:0] SPEED_5G  = 2'h2;
   localparam logic [1:0] SPEED_10G = 2'h3;
   // valid pacing, link clock cycles per beat
   localparam int PACE_W = 4;
   localparam logic [PACE_W-1:0] PACE_1G  = 4'ha;
   localparam logic [PACE_W-1:0] PACE_2G5 = 4'h4;
   localparam logic [PACE_W-1:0] PACE_5G  = 4'h2;
   localparam logic [PACE_W-1:0] PACE_10G = 4'h1;
   // idle beat: all lanes control, idle character
   localparam logic [WFIFO_W-1:0] WIDE_IDLE = {8'hff, {8{8'h07}}};

   function automatic logic [PACE_W-1:0] pace_period(input logic [1:0] s);
      case (s)
         SPEED_1G:  return PACE_1G;
         SPEED_2G5: return PACE_2G5;
         SPEED_5G:  return PACE_5G;
         default:   return PACE_10G;
      endcase
   endfunction : pace_period
endpackage : mr_link_pkg

// File: hdl/mr_link_if.sv
// wires between the device end and the mac end of the data port
// assumes: the bench drives linkClk, the parallel clock; the core clock is a separate clk
`timescale 1ns/1ns
`default_nettype none
interface mr_link_if
   import mr_link_pkg::*;
   (input wire logic linkClk);
   logic [NARROW_W-1:0]   narrowTxWord;
   logic [LANES-1:0]      narrowTxLaneEnable;
   logic [LANES-1:0]      narrowTxLaneError;
   logic [NARROW_W-1:0]   narrowRxWord;
   logic [LANES-1:0]      narrowRxLaneValid;
   logic [LANES-1:0]      narrowRxLaneError;
   logic [WIDE_W-1:0]     wideTxData;
   logic [WIDE_LANES-1:0] wideTxCtrl;
   logic                  wideTxValid;
   logic [WIDE_W-1:0]     wideRxData;
   logic [WIDE_LANES-1:0] wideRxCtrl;
   logic                  wideRxValid;
   logic [DELAY_W-1:0]    txPathDelayValue;
   logic [DELAY_W-1:0]    rxPathDelayValue;

   modport phy (input linkClk, narrowTxWord, narrowTxLaneEnable, narrowTxLaneError,
                wideTxData, wideTxCtrl, wideTxValid,
                output narrowRxWord, narrowRxLaneValid, narrowRxLaneError,
                wideRxData, wideRxCtrl, wideRxValid, txPathDelayValue, rxPathDelayValue);
   modport mac (input linkClk, narrowRxWord, narrowRxLaneValid, narrowRxLaneError,
                wideRxData, wideRxCtrl, wideRxValid, txPathDelayValue, rxPathDelayValue,
                output narrowTxWord, narrowTxLaneEnable, narrowTxLaneError,
                wideTxData, wideTxCtrl, wideTxValid);
endinterface : mr_link_if
`default_nettype wire

// File: hdl/mac_data_port_end.sv
// mac end of the multi-rate data port
// assumes: async_fifo is compiled first, linkClk comes from the bench
`timescale 1ns/1ns
`default_nettype none
module mac_data_port_end
   import mr_link_pkg::*;
#(
   parameter int FAW = FIFO_AW
) (
   input  wire logic                  clk,
   input  wire logic                  rstn,
   mr_link_if.mac                     link,
   input  wire logic [1:0]            speedMode,
   input  wire logic [NARROW_W-1:0]   txWord,
   input  wire logic [LANES-1:0]      txLaneEn,
   input  wire logic [LANES-1:0]      txLaneErr,
   input  wire logic                  txWordValid,
   output logic                       txWordReady,
   input  wire logic [WIDE_W-1:0]     txWideData,
   input  wire logic [WIDE_LANES-1:0] txWideCtrl,
   input  wire logic                  txWideValid,
   output logic                       txWideReady,
   output logic [NARROW_W-1:0]        rxWord,
   output logic [LANES-1:0]           rxLaneValid,
   output logic [LANES-1:0]           rxLaneErr,
   output logic                       rxWordValid,
   output logic [WIDE_W-1:0]          rxWideData,
   output logic [WIDE_LANES-1:0]      rxWideCtrl,
   output logic                       rxWideValid,
   output logic [DELAY_W-1:0]         txDelay,
   output logic [DELAY_W-1:0]         rxDelay
);
   logic [1:0]         lrst_q;
   logic               linkRstn;
   logic [1:0]         crst_q;
   logic               coreRstn;
   logic [1:0]         spS1_q, spS1_d;
   logic [1:0]         spS2_q, spS2_d;
   logic [NTX_W-1:0]   nTx_q, nTx_d;
   logic [WFIFO_W-1:0] wTx_q, wTx_d;
   logic               wTxV_q, wTxV_d;
   logic [PACE_W-1:0]  pace_q, pace_d;
   logic [NTX_W-1:0]   rxCap_q, rxCap_d;
   logic [WFIFO_W-1:0] wRxCap_q, wRxCap_d;
   logic               wRxCapV_q, wRxCapV_d;
   logic [DELAY_W-1:0] txDly_q, txDly_d;
   logic [DELAY_W-1:0] rxDly_q, rxDly_d;
   logic               tick;
   logic               txnAvail;
   logic [NTX_W-1:0]   txnData;
   logic               txwAvail;
   logic [WFIFO_W-1:0] txwData;
   logic [NTX_W-1:0]   rxnOut;
   logic [WFIFO_W-1:0] rxwOut;

   always_ff @(posedge link.linkClk or negedge rstn) begin
      if (!rstn) begin
         lrst_q <= 2'h0;
      end else begin
         lrst_q <= {lrst_q[0], 1'b1};
      end
   end
   assign linkRstn = lrst_q[1];

   // core-domain release, so the buffer pointers leave reset on a clean clk edge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         crst_q <= 2'h0;
      end else begin
         crst_q <= {crst_q[0], 1'b1};
      end
   end
   assign coreRstn = crst_q[1];

   ////////////////////////////////////////////////////////////////////
   assign tick = pace_q == '0;

   always_comb begin
      spS1_d    = speedMode;
      spS2_d    = spS1_q;
      // an empty buffer mid-frame drops enable; user must keep ahead
      nTx_d     = txnAvail ? txnData : '0;
      pace_d    = tick ? pace_period(spS2_q) - 4'h1 : pace_q - 4'h1;
      wTxV_d    = tick;
      wTx_d     = wTx_q;
      if (tick) begin
         wTx_d = txwAvail ? txwData : WIDE_IDLE;
      end
      rxCap_d   = {link.narrowRxLaneError, link.narrowRxLaneValid, link.narrowRxWord};
      wRxCap_d  = {link.wideRxCtrl, link.wideRxData};
      // pacing may slip, so capture on valid only
      wRxCapV_d = link.wideRxValid;
      txDly_d   = link.txPathDelayValue;
      rxDly_d   = link.rxPathDelayValue;
   end

   always_ff @(posedge link.linkClk or negedge linkRstn) begin
      if (!linkRstn) begin
         spS1_q    <= SPEED_1G;
         spS2_q    <= SPEED_1G;
         nTx_q     <= '0;
         wTx_q     <= '0;
         wTxV_q    <= 1'b0;
         pace_q    <= '0;
         rxCap_q   <= '0;
         wRxCap_q  <= '0;
         wRxCapV_q <= 1'b0;
         txDly_q   <= '0;
         rxDly_q   <= '0;
      end else begin
         spS1_q    <= spS1_d;
         spS2_q    <= spS2_d;
         nTx_q     <= nTx_d;
         wTx_q     <= wTx_d;
         wTxV_q    <= wTxV_d;
         pace_q    <= pace_d;
         rxCap_q   <= rxCap_d;
         wRxCap_q  <= wRxCap_d;
         wRxCapV_q <= wRxCapV_d;
         txDly_q   <= txDly_d;
         rxDly_q   <= rxDly_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   assign link.narrowTxWord       = nTx_q[NARROW_W-1:0];
   assign link.narrowTxLaneEnable = nTx_q[NARROW_W +: LANES];
   assign link.narrowTxLaneError  = nTx_q[NARROW_W+LANES +: LANES];
   assign link.wideTxData         = wTx_q[WIDE_W-1:0];
   assign link.wideTxCtrl         = wTx_q[WIDE_W +: WIDE_LANES];
   assign link.wideTxValid        = wTxV_q;
   assign txDelay                 = txDly_q;
   assign rxDelay                 = rxDly_q;

   async_fifo #(.W(NTX_W), .AW(FAW)) u_txn (
      .wClk(clk), .wRstn(coreRstn), .wValid(txWordValid), .wData({txLaneErr, txLaneEn, txWord}),
      .wReady(txWordReady),
      .rClk(link.linkClk), .rRstn(linkRstn), .rValid(txnAvail), .rData(txnData), .rReady(1'b1));

   async_fifo #(.W(WFIFO_W), .AW(FAW)) u_txw (
      .wClk(clk), .wRstn(coreRstn), .wValid(txWideValid), .wData({txWideCtrl, txWideData}),
      .wReady(txWideReady),
      .rClk(link.linkClk), .rRstn(linkRstn), .rValid(txwAvail), .rData(txwData), .rReady(tick));

   async_fifo #(.W(NTX_W), .AW(FAW)) u_rxn (
      .wClk(link.linkClk), .wRstn(linkRstn), .wValid(|rxCap_q[NARROW_W +: 2*LANES]),
      .wData(rxCap_q), .wReady(),
      .rClk(clk), .rRstn(coreRstn), .rValid(rxWordValid), .rData(rxnOut), .rReady(1'b1));

   async_fifo #(.W(WFIFO_W), .AW(FAW)) u_rxw (
      .wClk(link.linkClk), .wRstn(linkRstn), .wValid(wRxCapV_q), .wData(wRxCap_q), .wReady(),
      .rClk(clk), .rRstn(coreRstn), .rValid(rxWideValid), .rData(rxwOut), .rReady(1'b1));

   assign rxWord      = rxnOut[NARROW_W-1:0];
   assign rxLaneValid = rxnOut[NARROW_W +: LANES];
   assign rxLaneErr   = rxnOut[NARROW_W+LANES +: LANES];
   assign rxWideData  = rxwOut[WIDE_W-1:0];
   assign rxWideCtrl  = rxwOut[WIDE_W +: WIDE_LANES];
endmodule : mac_data_port_end
`default_nettype wire

// File: sim/mr_link_asserts.sv
// pacing and delay-value checks on the link between the two ends
// assumes: placed beside mr_link_if, speedMode held steady while traffic runs
`timescale 1ns/1ns
`default_nettype none
module mr_link_asserts
   import mr_link_pkg::*;
(
   input wire logic               linkClk,
   input wire logic               rstn,
   input wire logic [1:0]         speedMode,
   input wire logic               wideTxValid,
   input wire logic [WIDE_W-1:0]  wideTxData,
   input wire logic               wideRxValid,
   input wire logic [DELAY_W-1:0] txPathDelayValue,
   input wire logic [DELAY_W-1:0] rxPathDelayValue
);
   logic [1:0] spdMeta_q, spdMeta_d, spd_q, spd_d;
   logic [4:0] settle_q, settle_d;
   logic [3:0] txGap_q, txGap_d, rxGap_q, rxGap_d;
   logic       ok;

   default clocking @(posedge linkClk); endclocking
   default disable iff (!rstn);

   ////////////////////////////////////////////////////////////////////////
   // speed pipeline and gap counters; pacing is only judged once settled,
   // since a speed change lets the old count run out first
   always_comb begin
      spdMeta_d = speedMode;
      spd_d     = spdMeta_q;
      settle_d  = (spd_q != spdMeta_q) ? 5'h00 : ((settle_q == 5'h1f) ? settle_q : settle_q + 5'h01);
      txGap_d   = wideTxValid ? 4'h0 : ((txGap_q == 4'hf) ? txGap_q : txGap_q + 4'h1);
      rxGap_d   = wideRxValid ? 4'h0 : ((rxGap_q == 4'hf) ? rxGap_q : rxGap_q + 4'h1);
   end
   always_ff @(posedge linkClk or negedge rstn) begin
      if (!rstn) begin
         spdMeta_q <= 2'h0;
         spd_q     <= 2'h0;
         settle_q  <= 5'h00;
         txGap_q   <= 4'h0;
         rxGap_q   <= 4'h0;
      end else begin
         spdMeta_q <= spdMeta_d;
         spd_q     <= spd_d;
         settle_q  <= settle_d;
         txGap_q   <= txGap_d;
         rxGap_q   <= rxGap_d;
      end
   end
   assign ok = (settle_q == 5'h1f);

   ////////////////////////////////////////////////////////////////////////
   property p_tx_pace_1g;
      ok && spd_q == SPEED_1G && wideTxValid |-> txGap_q == PACE_1G - 4'h1;
   endproperty
   a_tx_pace_1g: assert property (p_tx_pace_1g) else $error("wide tx valid spacing wrong at 1G");
   property p_tx_pace_2g5;
      ok && spd_q == SPEED_2G5 && wideTxValid |=> !wideTxValid [*3] ##1 wideTxValid;
   endproperty
   a_tx_pace_2g5: assert property (p_tx_pace_2g5) else $error("wide tx valid spacing wrong at 2.5G");
   property p_tx_pace_5g;
      ok && spd_q == SPEED_5G |-> wideTxValid != $past(wideTxValid);
   endproperty
   a_tx_pace_5g: assert property (p_tx_pace_5g) else $error("wide tx valid not alternating at 5G");
   property p_tx_pace_10g;
      ok && spd_q == SPEED_10G |-> wideTxValid;
   endproperty
   a_tx_pace_10g: assert property (p_tx_pace_10g) else $error("wide tx valid dropped at 10G");
   property p_rx_pace_1g;
      ok && spd_q == SPEED_1G && wideRxValid |-> rxGap_q == PACE_1G - 4'h1;
   endproperty
   a_rx_pace_1g: assert property (p_rx_pace_1g) else $error("wide rx valid spacing wrong at 1G");
   property p_rx_pace_2g5;
      ok && spd_q == SPEED_2G5 && wideRxValid |-> rxGap_q == PACE_2G5 - 4'h1;
   endproperty
   a_rx_pace_2g5: assert property (p_rx_pace_2g5) else $error("wide rx valid spacing wrong at 2.5G");
   property p_rx_pace_5g;
      ok && spd_q == SPEED_5G && wideRxValid |=> !wideRxValid ##1 wideRxValid;
   endproperty
   a_rx_pace_5g: assert property (p_rx_pace_5g) else $error("wide rx valid spacing wrong at 5G");
   property p_rx_pace_10g;
      ok && spd_q == SPEED_10G |-> wideRxValid [*2];
   endproperty
   a_rx_pace_10g: assert property (p_rx_pace_10g) else $error("wide rx valid dropped at 10G");
   property p_tx_delay;
      ok |-> txPathDelayValue == {TX_LAT_CYC, LAT_FRAC};
   endproperty
   a_tx_delay: assert property (p_tx_delay) else $error("tx path delay value wrong");
   property p_rx_delay;
      ok |-> rxPathDelayValue == {RX_LAT_CYC, LAT_FRAC} && $stable(rxPathDelayValue);
   endproperty
   a_rx_delay: assert property (p_rx_delay) else $error("rx path delay value wrong or moving");
   property p_tx_hold;
      ok && !wideTxValid |-> $stable(wideTxData);
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("wide tx data moved between valids");
endmodule : mr_link_asserts
`default_nettype wire

// File: sim/testbench.sv
// self-checking bench: both ends joined by mr_link_if, traffic in all four directions
// assumes: package, interface, design ends and mr_link_asserts compiled first
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import mr_link_pkg::*;
   logic               clk = 1'b0;
   logic               linkClk = 1'b0;
   logic               rstn = 1'b0;
   logic [1:0]         speedMode = SPEED_1G;
   logic [NTX_W-1:0]   txIn = '0, rxIn = '0;
   logic [WFIFO_W-1:0] wtxIn = '0, wrxIn = '0;
   logic [3:0]         vld = 4'h0;
   wire logic [3:0]    rdy;
   wire logic [NTX_W-1:0]   txOut, rxOut;
   wire logic [WFIFO_W-1:0] wtxOut, wrxOut;
   wire logic          txOutV, wtxOutV, rxOutV, wrxOutV;
   wire logic [DELAY_W-1:0] txDly, rxDly;
   logic [WFIFO_W-1:0] q[4][$];
   int                 n_errors = 0;
   int                 tests_run = 0;
   integer             seed = 37497;

   always #2 clk = ~clk;
   // link clock from its own process, 15 ns period, so its phase drifts against clk
   always begin
      #8 linkClk = 1'b1;
      #7 linkClk = 1'b0;
   end

   mr_link_if u_mr_link_if (.linkClk(linkClk));
   multirate_phy_mac_data_port u_multirate_phy_mac_data_port (.clk(clk), .rstn(rstn),
      .link(u_mr_link_if.phy), .speedMode(speedMode),
      .txWord(txOut[19:4]), .txLaneEn(txOut[3:2]), .txLaneErr(txOut[1:0]), .txWordValid(txOutV),
      .txWideData(wtxOut[63:0]), .txWideCtrl(wtxOut[71:64]), .txWideValid(wtxOutV),
      .rxWord(rxIn[19:4]), .rxLaneValid(rxIn[3:2]), .rxLaneErr(rxIn[1:0]), .rxWordValid(vld[2]),
      .rxWordReady(rdy[2]), .rxWideData(wrxIn[63:0]), .rxWideCtrl(wrxIn[71:64]), .rxWideValid(vld[3]),
      .rxWideReady(rdy[3]));
   mac_data_port_end u_mac_data_port_end (.clk(clk), .rstn(rstn), .link(u_mr_link_if.mac),
      .speedMode(speedMode), .txWord(txIn[19:4]), .txLaneEn(txIn[3:2]), .txLaneErr(txIn[1:0]),
      .txWordValid(vld[0]), .txWordReady(rdy[0]), .txWideData(wtxIn[63:0]), .txWideCtrl(wtxIn[71:64]),
      .txWideValid(vld[1]), .txWideReady(rdy[1]), .rxWord(rxOut[19:4]), .rxLaneValid(rxOut[3:2]),
      .rxLaneErr(rxOut[1:0]), .rxWordValid(rxOutV), .rxWideData(wrxOut[63:0]),
      .rxWideCtrl(wrxOut[71:64]), .rxWideValid(wrxOutV), .txDelay(txDly), .rxDelay(rxDly));
   mr_link_asserts u_mr_link_asserts (.linkClk(linkClk), .rstn(rstn), .speedMode(speedMode),
      .wideTxValid(u_mr_link_if.wideTxValid), .wideTxData(u_mr_link_if.wideTxData),
      .wideRxValid(u_mr_link_if.wideRxValid), .txPathDelayValue(u_mr_link_if.txPathDelayValue),
      .rxPathDelayValue(u_mr_link_if.rxPathDelayValue));

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [WFIFO_W-1:0] seen, input logic [WFIFO_W-1:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // empty queue gives all ones, which no real beat carries
   function automatic logic [WFIFO_W-1:0] pop(input int k);
      if (q[k].size() == 0) return '1;
      return q[k].pop_front();
   endfunction : pop

   // k: 0 narrow tx, 1 wide tx, 2 narrow rx, 3 wide rx; valid stays up between beats
   task automatic drive(input int k, input int n);
      logic [WFIFO_W-1:0] v;
      logic               r;
      @(posedge clk);
      #1;
      for (int i = 0; i < n; i++) begin
         v = {8'($random(seed)) & 8'h7f, 32'($random(seed)), 32'($random(seed))};
         if (k % 2 == 0) v = {52'h0, v[19:4], (i == n - 1) ? 2'h1 : 2'h3, v[1:0] & {2{i == 3}}};
         case (k)
            0: txIn = v[19:0];
            1: wtxIn = v;
            2: rxIn = v[19:0];
            default: wrxIn = v;
         endcase
         vld[k] = 1'b1;
         do begin
            r = rdy[k];
            @(posedge clk);
            #1;
         end while (r !== 1'b1);
         q[k].push_back(v);
      end
      vld[k] = 1'b0;
   endtask : drive

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : wrap_up

   ////////////////////////////////////////////////////////////////////////
   // idle beats inserted on empty pacing slots are not traffic
   always @(negedge clk) begin
      if (txOutV === 1'b1) check(WFIFO_W'(txOut), pop(0));
      if (wtxOutV === 1'b1 && wtxOut !== WIDE_IDLE) check(wtxOut, pop(1));
      if (rxOutV === 1'b1) check(WFIFO_W'(rxOut), pop(2));
      if (wrxOutV === 1'b1 && wrxOut !== WIDE_IDLE) check(wrxOut, pop(3));
   end

   initial begin
      #100000;
      n_errors++;
      wrap_up();
   end

   initial begin
      repeat (12) @(posedge clk);
      #1 rstn = 1'b1;
      repeat (10) @(posedge linkClk);
      // look after the launching edge, not in its time step
      #1;
      check(WFIFO_W'(txDly), WFIFO_W'({TX_LAT_CYC, LAT_FRAC}));
      check(WFIFO_W'(rxDly), WFIFO_W'({RX_LAT_CYC, LAT_FRAC}));
      for (int s = 0; s < 4; s++) begin
         @(posedge clk);
         #1 speedMode = 2'(s);
         repeat (40) @(posedge linkClk);
         fork
            drive(0, 12);
            drive(1, 6);
            drive(2, 12);
            drive(3, 6);
         join
         for (int w = 0; w < 3000 && q[0].size() + q[1].size() + q[2].size() + q[3].size() > 0; w++)
            @(posedge clk);
         check(WFIFO_W'(q[0].size() + q[1].size() + q[2].size() + q[3].size()), '0);
      end
      repeat (60) @(posedge linkClk);
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
